// >>> csor_core_regs.sv
// Purpose: Status and option registers of an 8-bit core, Wishbone slave.
// Assumes: Pins are asynchronous; ticks and ALU requests are on clk_i.
// Notes:   Read of the event status register clears the bits read.
//
// Function
// RQ1 - ALU op updating flags with status destination keeps flags from result.
// RQ2 - Software writes never change the timeout and power-down bits.
// RQ3 - Clear-file on status zeroes upper three bits, sets zero flag.
// RQ4 - Software should alter status only with flag-neutral instructions.
// RQ5 - Software keeps unimplemented upper bank bits at zero.
// RQ6 - Carry and half carry are inverted borrows in subtraction.
// RQ7 - Subtraction adds the two's complement; flags come from that sum.
// RQ8 - Option bit 7 set disables all port B pull-ups.
// RQ9 - Option bit 6 picks rising or falling external interrupt edge.
// RQ10 - Option bit 5 picks external pin or instruction clock for timer.
// RQ11 - Option bit 4 picks falling or rising external timer edge.
// RQ12 - Option bit 3 gives the prescaler to watchdog or timer.
// RQ13 - Rate codes divide timer by 2 to 256, watchdog by 1 to 128.
// RQ14 - Software assigns prescaler to watchdog for undivided timer.
// RQ15 - All option bits are read-write and reset to one.
// RQ16 - Event flags set regardless of any enable.
// RQ17 - Bank bits select the memory bank for direct and indirect access.
// RQ18 - Zero, half carry and carry follow the result and its carries.
// RQ19 - Power-up, watchdog clear, sleep and timeout drive the reset bits.
`include "csor_consts.svh"
module csor_core_regs
    import csor_pkg::*;
#(
    parameter int DW  = 32,
    parameter int AW  = 12,
    parameter int PBW = 8
) (
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    input  wire logic [AW-1:0]    adr_i,
    input  wire logic [DW-1:0]    dat_i,
    output logic      [DW-1:0]    dat_o,
    input  wire logic             we_i,
    input  wire logic [DW/8-1:0]  sel_i,
    input  wire logic             stb_i,
    input  wire logic             cyc_i,
    output logic                  ack_o,
    input  wire csor_alu_req_type alu_req_i,
    output logic      [7:0]       alu_result_o,
    output logic                  alu_done_o,
    input  wire logic             clrwdt_i,
    input  wire logic             sleep_i,
    input  wire logic             wdt_timeout_i,
    input  wire logic             instr_tick_i,
    input  wire logic             wdt_osc_tick_i,
    input  wire logic             timer_ext_clk_pin_i,
    input  wire logic             ext_irq_pin_i,
    input  wire logic [PBW-1:0]   port_b_latch_i,
    input  wire logic [6:0]       dir_offset_i,
    input  wire logic [7:0]       ind_ptr_i,
    output csor_status_type       status_o,
    output csor_option_type       option_o,
    output logic      [PBW-1:0]   port_b_pullup_o,
    output logic                  timer0_inc_o,
    output logic                  watchdog_tick_o,
    output logic      [8:0]       dir_addr_o,
    output logic      [8:0]       ind_addr_o,
    output logic                  irq_o
);

    // ------------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------------
    function automatic logic [9:0] csor_add(input logic [7:0] a,
                                            input logic [7:0] b,
                                            input logic       sub);
        logic [7:0] bb;
        logic [8:0] full;
        logic [4:0] half;
        bb   = sub ? ~b : b;
        full = {1'b0, a} + {1'b0, bb} + {8'h00, sub};
        half = {1'b0, a[3:0]} + {1'b0, bb[3:0]} + {4'h0, sub};
        return {full[8], half[4], full[7:0]};
    endfunction : csor_add

    function automatic logic [7:0] csor_rate_mask(input logic [2:0] rate,
                                                  input logic       wdt);
        logic [3:0] n;
        logic [8:0] m;
        n = wdt ? {1'b0, rate} : {1'b0, rate} + 4'h1;
        m = (9'h001 << n) - 9'h001;
        return m[7:0];
    endfunction : csor_rate_mask

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    localparam int EVW = $bits(csor_event_type);

    csor_status_type           status;
    csor_status_type           next_status;
    csor_option_type           option;
    csor_event_type            irq_stat;
    csor_event_type            irq_mask;
    csor_event_type            next_irq_stat;
    csor_event_type            events;
    csor_event_type            irq_clr;
    logic [AW-3:0]             idx;
    logic                      acc;
    logic                      bus_req;
    logic                      bus_fire;
    logic                      wr_fire;
    logic [DW-1:0]             rd_data;
    logic [9:0]                sum;
    logic [7:0]                alu_res;
    logic                      arith;
    logic                      zonly;
    logic [1:0]                sync1;
    logic [1:0]                sync2;
    logic [1:0]                sync3;
    logic [1:0]                filt;
    logic [1:0]                filt_d;
    logic [1:0]                rise;
    logic [1:0]                fall;
    logic                      ext_ev;
    logic                      src_tick;
    logic                      pre_in;
    logic                      pre_out;
    logic [`CSOR_PRE_WIDTH-1:0] pre_cnt;

    // ------------------------------------------------------------------
    // Wishbone slave
    // ------------------------------------------------------------------
    assign idx      = adr_i[AW-1:2];
    assign acc      = cyc_i & stb_i;
    assign bus_req  = acc & ~ack_o;
    assign bus_fire = acc & ack_o;
    assign wr_fire  = bus_fire & we_i & sel_i[0];

    always_comb begin
        rd_data = '0;
        case (idx)
            (AW-2)'(`CSOR_IDX_STATUS):   rd_data = DW'(status);
            (AW-2)'(`CSOR_IDX_OPTION):   rd_data = DW'(option);
            (AW-2)'(`CSOR_IDX_IRQ_STAT): rd_data = DW'(irq_stat);
            (AW-2)'(`CSOR_IDX_IRQ_MASK): rd_data = DW'(irq_mask);
            default:                     rd_data = '0;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
        end else begin
            ack_o <= bus_req;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_o <= '0;
        end else if (bus_req) begin
            dat_o <= rd_data;
        end
    end

    // ------------------------------------------------------------------
    // ALU
    // ------------------------------------------------------------------
    always_comb begin
        sum     = csor_add(alu_req_i.a, alu_req_i.b,
                           alu_req_i.op == CSOR_OP_SUB); // RQ7
        alu_res = alu_req_i.a;
        arith   = 1'b0;
        zonly   = 1'b0;
        unique case (alu_req_i.op)
            CSOR_OP_ADD, CSOR_OP_SUB: begin
                alu_res = sum[7:0];
                arith   = 1'b1;
            end
            CSOR_OP_AND: begin
                alu_res = alu_req_i.a & alu_req_i.b;
                zonly   = 1'b1;
            end
            CSOR_OP_IOR: begin
                alu_res = alu_req_i.a | alu_req_i.b;
                zonly   = 1'b1;
            end
            CSOR_OP_XOR: begin
                alu_res = alu_req_i.a ^ alu_req_i.b;
                zonly   = 1'b1;
            end
            CSOR_OP_CLR: begin
                alu_res = 8'h00;
                zonly   = 1'b1;
            end
            CSOR_OP_MOV, CSOR_OP_NONE: begin
                alu_res = alu_req_i.a;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            alu_result_o <= 8'h00;
            alu_done_o   <= 1'b0;
        end else begin
            alu_result_o <= alu_res;
            alu_done_o   <= alu_req_i.valid;
        end
    end

    // ------------------------------------------------------------------
    // Status register
    // ------------------------------------------------------------------
    always_comb begin
        next_status = status;
        if (wr_fire && idx == (AW-2)'(`CSOR_IDX_STATUS)) begin
            next_status = csor_status_type'(
                (status & ~`CSOR_STATUS_WMASK) |
                (dat_i[7:0] & `CSOR_STATUS_WMASK)); // RQ2
        end
        if (alu_req_i.valid) begin
            if (alu_req_i.to_status) begin
                next_status = csor_status_type'(
                    (status & ~((arith | zonly) ? `CSOR_UPPER3_MASK :
                                `CSOR_STATUS_WMASK)) |
                    (alu_res & ((arith | zonly) ? `CSOR_UPPER3_MASK :
                                `CSOR_STATUS_WMASK))); // RQ1 RQ2 RQ3
            end
            if (arith) begin
                next_status.carry_flag      = sum[9]; // RQ6 RQ18
                next_status.half_carry_flag = sum[8]; // RQ6 RQ18
            end
            if (arith || zonly) begin
                next_status.zero_flag = (alu_res == 8'h00); // RQ18 RQ3
            end
        end
        if (clrwdt_i) begin
            next_status.watchdog_timeout_n = 1'b1; // RQ19
            next_status.powerdown_n        = 1'b1; // RQ19
        end
        if (sleep_i) begin
            next_status.watchdog_timeout_n = 1'b1; // RQ19
            next_status.powerdown_n        = 1'b0; // RQ19
        end
        if (wdt_timeout_i) begin
            next_status.watchdog_timeout_n = 1'b0; // RQ19
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            status <= csor_status_type'(`CSOR_STATUS_RST); // RQ19
        end else begin
            status <= next_status;
        end
    end

    // ------------------------------------------------------------------
    // Option register and bank addressing
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            option <= csor_option_type'(`CSOR_OPTION_RST); // RQ15
        end else if (wr_fire && idx == (AW-2)'(`CSOR_IDX_OPTION)) begin
            option <= csor_option_type'(dat_i[7:0]); // RQ15
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            status_o        <= csor_status_type'(`CSOR_STATUS_RST);
            option_o        <= csor_option_type'(`CSOR_OPTION_RST);
            port_b_pullup_o <= '0;
            dir_addr_o      <= 9'h000;
            ind_addr_o      <= 9'h000;
        end else begin
            status_o        <= next_status;
            option_o        <= option;
            port_b_pullup_o <= port_b_latch_i &
                               {PBW{~option.port_b_pullup_off}}; // RQ8
            dir_addr_o      <= {status.direct_bank_select_hi,
                                status.direct_bank_select_lo,
                                dir_offset_i}; // RQ17
            ind_addr_o      <= {status.indirect_bank_select,
                                ind_ptr_i}; // RQ17
        end
    end

    // ------------------------------------------------------------------
    // Pin synchronisers, index 0 interrupt pin, index 1 timer pin
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sync1  <= 2'h0;
            sync2  <= 2'h0;
            sync3  <= 2'h0;
            filt   <= 2'h0;
            filt_d <= 2'h0;
        end else begin
            sync1  <= {timer_ext_clk_pin_i, ext_irq_pin_i};
            sync2  <= sync1;
            sync3  <= sync2;
            filt   <= (sync2 & sync3) | (filt & (sync2 ^ sync3));
            filt_d <= filt;
        end
    end

    assign rise     = filt & ~filt_d;
    assign fall     = ~filt & filt_d;
    assign ext_ev   = option.ext_irq_edge_sel ? rise[0] : fall[0]; // RQ9
    assign src_tick = option.timer_clk_src_sel ?
                      (option.timer_ext_edge_sel ? fall[1] : rise[1]) :
                      instr_tick_i; // RQ10 RQ11

    // ------------------------------------------------------------------
    // Shared prescaler
    // ------------------------------------------------------------------
    assign pre_in  = option.prescaler_assign ? wdt_osc_tick_i
                                             : src_tick; // RQ12
    assign pre_out = pre_in &&
        (((pre_cnt + `CSOR_PRE_WIDTH'(1)) &
          csor_rate_mask(option.prescaler_rate,
                         option.prescaler_assign)) == '0); // RQ13

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pre_cnt <= '0;
        end else if (pre_in) begin
            pre_cnt <= pre_cnt + `CSOR_PRE_WIDTH'(1);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            timer0_inc_o    <= 1'b0;
            watchdog_tick_o <= 1'b0;
        end else begin
            timer0_inc_o    <= option.prescaler_assign ? src_tick
                                                       : pre_out; // RQ12
            watchdog_tick_o <= option.prescaler_assign ? pre_out
                                                       : wdt_osc_tick_i;
        end
    end

    // ------------------------------------------------------------------
    // Event status, mask and interrupt
    // ------------------------------------------------------------------
    assign events  = '{sleep_entry: sleep_i, wdt_timeout: wdt_timeout_i,
                       ext_irq: ext_ev};
    assign irq_clr = (bus_fire && !we_i &&
                      idx == (AW-2)'(`CSOR_IDX_IRQ_STAT)) ?
                     csor_event_type'(dat_o[EVW-1:0]) : '0;
    assign next_irq_stat = (irq_stat & ~irq_clr) | events; // RQ16

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_stat <= `CSOR_IRQ_RST;
            irq_mask <= `CSOR_IRQ_RST;
            irq_o    <= 1'b0;
        end else begin
            irq_stat <= next_irq_stat;
            if (wr_fire && idx == (AW-2)'(`CSOR_IDX_IRQ_MASK)) begin
                irq_mask <= csor_event_type'(dat_i[EVW-1:0]);
            end
            irq_o <= |(next_irq_stat & irq_mask);
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    a_ack_single_pulse: assert property (ack_o |=> !ack_o)
        else $error("ack held longer than one cycle");
    a_status_reset_ro: assert property ( // RQ2
        wr_fire && idx == (AW-2)'(`CSOR_IDX_STATUS) && !alu_req_i.valid
        && !clrwdt_i && !sleep_i && !wdt_timeout_i
        |=> $stable(status.watchdog_timeout_n) && $stable(status.powerdown_n))
        else $error("software changed timeout or power-down bit");
    a_flags_from_alu: assert property ( // RQ1
        alu_req_i.valid && alu_req_i.to_status &&
        alu_req_i.op == CSOR_OP_ADD
        |=> status.carry_flag == $past(sum[9]) &&
            status.zero_flag == ($past(sum[7:0]) == 8'h00))
        else $error("status flags taken from written data");
    a_clear_file_status: assert property ( // RQ3
        alu_req_i.valid && alu_req_i.to_status &&
        alu_req_i.op == CSOR_OP_CLR && !wr_fire
        |=> status.zero_flag && !status.indirect_bank_select &&
            !status.direct_bank_select_hi && !status.direct_bank_select_lo &&
            $stable(status.carry_flag) && $stable(status.half_carry_flag))
        else $error("clear of status gave wrong value");
    a_sub_borrow_flag: assert property ( // RQ6
        alu_req_i.valid && alu_req_i.op == CSOR_OP_SUB
        |=> status.carry_flag == ($past(alu_req_i.a) >= $past(alu_req_i.b))
            && alu_result_o == $past(alu_req_i.a - alu_req_i.b))
        else $error("subtraction borrow wrong");
    a_pullup_disable: assert property ( // RQ8
        option.port_b_pullup_off |=> port_b_pullup_o == '0)
        else $error("pull-ups on while disabled");
    a_option_write: assert property ( // RQ15
        wr_fire && idx == (AW-2)'(`CSOR_IDX_OPTION)
        |=> option == $past(dat_i[7:0]) ##1 option_o == $past(option))
        else $error("option write lost");
    a_timer_undivided: assert property ( // RQ12
        option.prescaler_assign && src_tick |=> timer0_inc_o)
        else $error("timer divided while prescaler on watchdog");
    a_event_sets_flag: assert property ( // RQ16
        events.ext_irq |=> irq_stat.ext_irq)
        else $error("event flag not set");
    a_timeout_clears_to: assert property ( // RQ19
        wdt_timeout_i |=> !status.watchdog_timeout_n &&
                          irq_stat.wdt_timeout)
        else $error("timeout did not clear the timeout bit");

    c_status_write: cover property (
        wr_fire && idx == (AW-2)'(`CSOR_IDX_STATUS));
    c_sub_borrow: cover property (
        alu_req_i.valid && alu_req_i.op == CSOR_OP_SUB ##1 !status.carry_flag);
    c_irq_raised: cover property (!irq_o ##1 irq_o);
    c_prescaled_tick: cover property (!option.prescaler_assign && pre_out);

endmodule : csor_core_regs

// >>> csor_consts.svh
// Purpose: Constants of the core status and option register bank.
// Assumes: Included by the package and the register bank module.
// Notes:   Indices are word indices; byte address is four times each.
`ifndef CSOR_CONSTS_SVH
`define CSOR_CONSTS_SVH

// ----------------------------------------------------------------------
// Register indices
// ----------------------------------------------------------------------
`define CSOR_IDX_STATUS   10'h003
`define CSOR_IDX_OPTION   10'h081
`define CSOR_IDX_IRQ_STAT 10'h100
`define CSOR_IDX_IRQ_MASK 10'h101

// ----------------------------------------------------------------------
// Reset values and write masks
// ----------------------------------------------------------------------
`define CSOR_STATUS_RST   8'h18
`define CSOR_OPTION_RST   8'hFF
`define CSOR_IRQ_RST      3'h0
`define CSOR_STATUS_WMASK 8'hE7
`define CSOR_UPPER3_MASK  8'hE0
`define CSOR_PRE_WIDTH    8

`endif

// >>> csor_pkg.sv
// Purpose: Types of the core status and option register bank.
// Assumes: Nothing beyond the constants header.
// Notes:   Field order of each struct is the register's bit order.
`include "csor_consts.svh"

package csor_pkg;

    // ------------------------------------------------------------------
    // Register layouts
    // ------------------------------------------------------------------
    typedef struct packed {
        logic indirect_bank_select;
        logic direct_bank_select_hi;
        logic direct_bank_select_lo;
        logic watchdog_timeout_n;
        logic powerdown_n;
        logic zero_flag;
        logic half_carry_flag;
        logic carry_flag;
    } csor_status_type;

    typedef struct packed {
        logic       port_b_pullup_off;
        logic       ext_irq_edge_sel;
        logic       timer_clk_src_sel;
        logic       timer_ext_edge_sel;
        logic       prescaler_assign;
        logic [2:0] prescaler_rate;
    } csor_option_type;

    typedef struct packed {
        logic sleep_entry;
        logic wdt_timeout;
        logic ext_irq;
    } csor_event_type;

    // ------------------------------------------------------------------
    // ALU request
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        CSOR_OP_NONE, CSOR_OP_ADD, CSOR_OP_SUB, CSOR_OP_AND,
        CSOR_OP_IOR, CSOR_OP_XOR, CSOR_OP_CLR, CSOR_OP_MOV
    } csor_alu_op_type;

    typedef struct packed {
        logic            valid;
        csor_alu_op_type op;
        logic [7:0]      a;
        logic [7:0]      b;
        logic            to_status;
    } csor_alu_req_type;

endpackage : csor_pkg

// >>> tb_core_status_option_regs.sv
// Purpose: Self-checking bench of the status and option register bank.
// Assumes: The bus answers within 50 cycles; pins settle in 10 cycles.
// Notes:   Two counters tally the timer and watchdog tick pulses.
module tb_core_status_option_regs
    import csor_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    // ------------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------------
    logic             clk_i, rst_i, we_i, stb_i, cyc_i, ack_o, irq_o;
    logic             clrwdt_i, sleep_i, wdt_timeout_i, alu_done_o;
    logic             instr_tick_i, wdt_osc_tick_i, timer0_inc_o;
    logic             timer_ext_clk_pin_i, ext_irq_pin_i, watchdog_tick_o;
    logic [11:0]      adr_i;
    logic [31:0]      dat_i, dat_o;
    logic [3:0]       sel_i;
    logic [7:0]       port_b_latch_i, ind_ptr_i, alu_result_o;
    logic [7:0]       port_b_pullup_o;
    logic [6:0]       dir_offset_i;
    logic [8:0]       dir_addr_o, ind_addr_o;
    csor_alu_req_type alu_req_i;
    csor_status_type  status_o;
    csor_option_type  option_o;
    int               mismatches, total_checks, tc, wc;

    csor_core_regs csor_core_regs_i (.*);

    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    always @(posedge clk_i) begin
        if (timer0_inc_o === 1'b1) tc++;
        if (watchdog_tick_o === 1'b1) wc++;
    end
    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task report_and_stop();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : report_and_stop

    task wb(input logic [11:0] a, input logic w, input logic [7:0] d,
            output logic [31:0] q);
        int n;
        @(posedge clk_i);
        {adr_i, we_i, dat_i} <= {a, w, 24'h000000, d};
        {sel_i, cyc_i, stb_i} <= {4'hF, 1'b1, 1'b1};
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && n < 50);
        q = dat_o;
        if (n >= 50) mismatches++;
        {cyc_i, stb_i, we_i} <= 3'h0;
    endtask : wb

    task wr(input logic [11:0] a, input logic [7:0] d);
        logic [31:0] q;
        wb(a, 1'b1, d, q);
    endtask : wr

    task rd(input logic [11:0] a, input logic [7:0] e);
        logic [31:0] q;
        wb(a, 1'b0, 8'h00, q);
        chk("read data", {24'h000000, e}, q);
    endtask : rd

    task alu(input csor_alu_op_type op, input logic [7:0] a, b,
             input logic ts, input logic [7:0] er, es);
        @(posedge clk_i);
        alu_req_i <= '{1'b1, op, a, b, ts};
        @(posedge clk_i);
        alu_req_i.valid <= 1'b0;
        #1;
        chk("alu done", 1, alu_done_o);
        chk("alu result", er, alu_result_o);
        chk("status", es, status_o);
    endtask : alu

    task pulse(input logic [2:0] m, input logic [7:0] es, input logic q);
        @(posedge clk_i);
        {sleep_i, wdt_timeout_i, clrwdt_i} <= m;
        @(posedge clk_i);
        {sleep_i, wdt_timeout_i, clrwdt_i} <= 3'h0;
        repeat (3) @(posedge clk_i);
        #1;
        chk("status", es, status_o);
        chk("irq", q, irq_o);
    endtask : pulse

    task pin(input logic t, input logic v, input logic [7:0] e);
        @(posedge clk_i);
        if (t) timer_ext_clk_pin_i <= v;
        else ext_irq_pin_i <= v;
        tc = 0;
        repeat (10) @(posedge clk_i);
        if (t) chk("timer incs", e, tc);
        else rd(12'h400, e);
    endtask : pin

    task pre(input logic [7:0] opt, input int et, ew);
        wr(12'h204, opt);
        repeat (2) @(posedge clk_i);
        {tc, wc} = 0;
        {instr_tick_i, wdt_osc_tick_i} <= 2'h3;
        repeat (32) @(posedge clk_i);
        {instr_tick_i, wdt_osc_tick_i} <= 2'h0;
        repeat (4) @(posedge clk_i);
        chk("timer incs", et, tc);
        chk("watchdog ticks", ew, wc);
    endtask : pre

    initial begin
        {we_i, stb_i, cyc_i, clrwdt_i, sleep_i, wdt_timeout_i} = 6'h00;
        {instr_tick_i, wdt_osc_tick_i, timer_ext_clk_pin_i} = 3'h0;
        {adr_i, dat_i, sel_i, alu_req_i, ext_irq_pin_i} = '0;
        {port_b_latch_i, dir_offset_i, ind_ptr_i} = {8'hA5, 7'h55, 8'hA5};
        rst_i = 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(12'h00C, 8'h18);
        rd(12'h204, 8'hFF);
        rd(12'h400, 8'h00);
        rd(12'h7FC, 8'h00);
        wr(12'h00C, 8'h00);
        rd(12'h00C, 8'h18);
        alu(CSOR_OP_SUB, 8'h05, 8'h03, 1'b0, 8'h02, 8'h1B);
        alu(CSOR_OP_SUB, 8'h03, 8'h05, 1'b0, 8'hFE, 8'h18);
        alu(CSOR_OP_ADD, 8'h88, 8'h88, 1'b1, 8'h10, 8'h1B);
        wr(12'h00C, 8'hE3);
        alu(CSOR_OP_CLR, 8'h00, 8'h00, 1'b1, 8'h00, 8'h1F);
        alu(CSOR_OP_MOV, 8'h23, 8'h00, 1'b1, 8'h23, 8'h3B);
        alu(CSOR_OP_AND, 8'hF0, 8'h0F, 1'b0, 8'h00, 8'h3F);
        alu(CSOR_OP_IOR, 8'h01, 8'h00, 1'b0, 8'h01, 8'h3B);
        alu(CSOR_OP_XOR, 8'hAA, 8'hAA, 1'b0, 8'h00, 8'h3F);
        wr(12'h00C, 8'h60);
        @(posedge clk_i);
        #1 chk("dir addr", 9'h1D5, dir_addr_o);
        wr(12'h00C, 8'h80);
        @(posedge clk_i);
        #1 chk("ind addr", 9'h1A5, ind_addr_o);
        wr(12'h404, 8'h00);
        pulse(3'h2, 8'h88, 1'b0);
        rd(12'h400, 8'h02);
        wr(12'h404, 8'h07);
        pulse(3'h4, 8'h90, 1'b1);
        rd(12'h400, 8'h04);
        pulse(3'h1, 8'h98, 1'b0);
        wr(12'h204, 8'h40);
        pin(1'b0, 1'b1, 8'h01);
        pin(1'b0, 1'b0, 8'h00);
        wr(12'h204, 8'h00);
        pin(1'b0, 1'b1, 8'h00);
        pin(1'b0, 1'b0, 8'h01);
        rd(12'h204, 8'h00);
        chk("option", 8'h00, option_o);
        chk("pullups", 8'hA5, port_b_pullup_o);
        wr(12'h204, 8'h80);
        repeat (2) @(posedge clk_i);
        chk("pullups", 8'h00, port_b_pullup_o);
        pre(8'h00, 16, 32);
        pre(8'h02, 4, 32);
        pre(8'h08, 32, 32);
        pre(8'h0A, 32, 8);
        pre(8'h20, 0, 32);
        wr(12'h204, 8'h28);
        pin(1'b1, 1'b1, 8'h01);
        pin(1'b1, 1'b0, 8'h00);
        wr(12'h204, 8'h38);
        pin(1'b1, 1'b1, 8'h00);
        pin(1'b1, 1'b0, 8'h01);
        report_and_stop();
    end

    initial begin
        #100000;
        mismatches++;
        report_and_stop();
    end
endmodule : tb_core_status_option_regs
